// File: sim/shi_host_model.sv
`timescale 1ns/100ps
module shi_host_model (
    input  wire logic clk_in,
    input  wire logic so_in,
    output logic      sck_out,
    output logic      si_out,
    output logic      cs_n_out,
    output logic      sync_out,
    output logic      stream_clock_out,
    output logic      stream_serial_in_out
);
    // Clocks rest still and both selects start high; compat streams leave the byte sync low outside frames
    initial
    begin
        {sck_out, si_out, cs_n_out, sync_out, stream_clock_out, stream_serial_in_out} = 6'h0E;
    end

    // One bit: data changes with the fall, SO is taken late in the low half
    task automatic clk_bit(input logic comp, input logic b, output logic s);
        sck_out   <= 1'b0;
        stream_clock_out  <= comp ? 1'b0 : stream_clock_out;
        si_out    <= comp ? ~si_out : b;
        stream_serial_in_out <= comp ? b : stream_serial_in_out;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in) s = so_in;
        @(posedge clk_in);
        sck_out  <= !comp;
        stream_clock_out <= comp ? 1'b1 : stream_clock_out;
        repeat (4) @(posedge clk_in);
    endtask : clk_bit

    // Command frame, MSB first; fewer than 32 bits ends it early by the select
    task automatic cmd(input logic [31:0] w, input int n, output logic [15:0] rd);
        logic s;
        rd = 16'h0000;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < n; i++)
        begin
            clk_bit(1'b0, w[31-i], s);
            rd = {rd[14:0], s};
        end
        sck_out <= 1'b0;
        si_out  <= ~si_out; // Released data shows the inverse, so a stale bit cannot pass
        repeat (4) @(posedge clk_in);
        cs_n_out <= 1'b1;
        repeat (5) @(posedge clk_in);
    endtask : cmd

    // Stream word, MSB first; mode 0 native, 1 compat, 2 shared select
    task automatic stream(input logic [31:0] w, input int mode);
        logic s;
        @(posedge clk_in);
        sync_out <= (mode == 2); // Shared select leaves the pin high
        for (int i = 0; i < 3 && mode == 1; i++)
            clk_bit(1'b1, 1'b1, s); // Rises before the sync are no byte start
        repeat (4) @(posedge clk_in);
        sync_out <= (mode != 0);
        repeat (4) @(posedge clk_in);
        for (int i = 0; i < 32; i++)
            clk_bit(mode == 1, w[31-i], s);
        sck_out  <= 1'b0;
        stream_clock_out <= (mode == 1) ? 1'b0 : stream_clock_out;
        si_out   <= ~si_out;
        repeat (4) @(posedge clk_in);
        sync_out <= (mode != 1);
        repeat (4) @(posedge clk_in);
    endtask : stream
endmodule : shi_host_model

// File: sim/tb.sv
`timescale 1ns/100ps
module tb;
    import shi_pkg::*;
    logic        clk, nrst, done, rdy, sck, si, cs_n, sync, stream_clock, sdat;
    logic        so, oe, req, wr_p, rd_p, valid, native, shared, gio2, gio3;
    logic [7:0]  addr;
    logic [15:0] rdata, rword, wdata;
    logic [31:0] sword;
    int          bad_count, comparisons, cycles, wr_cnt, rd_cnt, oe_seen, n;

    shi_top dut_u (
        .CLK_IN(clk), .NRST_IN(nrst), .CE_IN(1'b1), .SCK_IN(sck), .SI_IN(si),
        .COMMAND_SELECT_N_IN(cs_n), .BYTE_SYNC_IN(sync), .STREAM_CLOCK_IN(stream_clock),
        .STREAM_SERIAL_IN(sdat), .REG_RDATA_IN(rdata), .REG_DONE_IN(done),
        .STREAM_READY_IN(rdy), .SO_OUT(so), .SO_OE_OUT(oe), .DATA_REQUEST_OUT(req),
        .REG_WRITE_OUT(wr_p), .REG_READ_OUT(rd_p), .REG_ADDR_OUT(addr),
        .REG_WDATA_OUT(wdata), .STREAM_DATA_OUT(sword), .STREAM_VALID_OUT(valid),
        .NATIVE_MODE_OUT(native), .SHARED_SELECT_OUT(shared),
        .GENERAL_IO_TWO_OUT(gio2), .GENERAL_IO_THREE_OUT(gio3)
    );
    // An undriven output reads as the inverse, so a missing enable corrupts the word
    shi_host_model host_u (
        .clk_in(clk), .so_in(oe ? so : !so), .sck_out(sck), .si_out(si), .cs_n_out(cs_n),
        .sync_out(sync), .stream_clock_out(stream_clock), .stream_serial_in_out(sdat)
    );

    // 100 MHz system clock
    always #5 clk = ~clk;

    // Pulses and drive seen during a frame; a hang ends the run
    always @(negedge clk)
    begin
        cycles++;
        wr_cnt += int'(wr_p === 1'b1);
        rd_cnt += int'(rd_p === 1'b1);
        oe_seen |= int'(oe === 1'b1);
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    // Compare and count; an unknown never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Bounded wait for the request to come back
    task automatic wait_req();
        @(negedge clk);
        for (int i = 0; i < 200 && req !== 1'b1; i++)
            @(negedge clk);
        check(req, 1'b1);
    endtask : wait_req

    // One command frame; a busy frame is closed by the done handshake
    task automatic run_cmd(input logic [31:0] w, input int bits, input int wr, input int rd);
        wr_cnt = 0;
        rd_cnt = 0;
        oe_seen = 0;
        host_u.cmd(w, bits, rword);
        @(negedge clk);
        check(wr_cnt, wr);
        check(rd_cnt, rd);
        check(oe_seen, rd);
        check(oe, 1'b0);
        if (wr + rd > 0)
        begin
            check(req, 1'b0);
            @(posedge clk) done <= 1'b1;
            @(posedge clk) done <= 1'b0;
        end
        wait_req();
    endtask : run_cmd

    // Take one word from the stalled output, then release it
    task automatic get_word(input logic [31:0] exp);
        @(negedge clk);
        for (int i = 0; i < 200 && valid !== 1'b1; i++)
            @(negedge clk);
        check(sword, exp);
        @(posedge clk) rdy <= 1'b1;
        @(posedge clk) rdy <= 1'b0;
    endtask : get_word

    // Reset state, and native pins read back as general io
    task automatic t_reset();
        @(negedge clk);
        check({native, shared, oe}, 3'b100);
        wait_req();
        repeat (8) @(negedge clk);
        check({gio2, gio3}, 2'b10);
        $display("reset test done");
    endtask : t_reset

    // Register write keeps SO released
    task automatic t_write();
        run_cmd({CMD_WRITE, 8'h5A, 16'hC3A5}, 32, 1, 0);
        check({addr, wdata}, 24'h5AC3A5);
        $display("write test done");
    endtask : t_write

    // Register read shifts the word out on SO
    task automatic t_read();
        @(posedge clk) rdata <= 16'h9A6B;
        run_cmd({CMD_READ, 8'h21, 16'h0000}, 32, 0, 1);
        check({addr, rword}, 24'h219A6B);
        $display("read test done");
    endtask : t_read

    // Unknown instruction, then a write cut short by the select
    task automatic t_refuse();
        run_cmd({8'h05, 8'h5A, 16'h1234}, 32, 0, 0);
        run_cmd({CMD_WRITE, 8'h66, 16'h1234}, 20, 0, 0);
        $display("refuse test done");
    endtask : t_refuse

    // Stalled drain: fill until the request drops, then empty in order
    task automatic t_fill();
        n = 0;
        while (req === 1'b1 && n < 12)
        begin
            host_u.stream(32'hA0B1C2D3 ^ {4{8'(n)}}, 0);
            n++;
            @(negedge clk);
        end
        check(n, 9);
        // Command while the request is low: closed by the done handshake, the request stays low
        host_u.cmd({CMD_WRITE, 8'h3C, 16'h0F0F}, 32, rword);
        @(posedge clk) done <= 1'b1;
        @(posedge clk) done <= 1'b0;
        repeat (8) @(negedge clk);
        check({req, addr, wdata}, 25'h03C0F0F);
        for (int i = 0; i < n; i++)
        begin
            repeat (3) @(posedge clk);
            get_word(32'hA0B1C2D3 ^ {4{8'(i)}});
        end
        @(negedge clk);
        check(valid, 1'b0);
        wait_req();
        $display("fill test done");
    endtask : t_fill

    // Compatibility mode: link clock and byte sync carry the stream
    task automatic t_compat();
        run_cmd({CMD_WRITE, MODE_ADDR, 16'h0000}, 32, 1, 0);
        check({native, gio2, gio3}, 3'b000);
        host_u.stream(32'h5C3A9617, 1);
        get_word(32'h5C3A9617);
        $display("compat test done");
    endtask : t_compat

    // Compatibility with shared select: bits only while sync is high
    task automatic t_passive();
        run_cmd({CMD_WRITE, MODE_ADDR, 16'h0400}, 32, 1, 0);
        check({native, shared}, 2'b01);
        host_u.stream(32'h96E14B2D, 1);
        get_word(32'h96E14B2D);
        $display("passive test done");
    endtask : t_passive

    // Shared select: stream framed by the idle command select
    task automatic t_shared();
        run_cmd({CMD_WRITE, MODE_ADDR, 16'h0C00}, 32, 1, 0);
        check({native, shared}, 2'b11);
        host_u.stream(32'h3CC3E11E, 2);
        get_word(32'h3CC3E11E);
        $display("shared test done");
    endtask : t_shared

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    // Reset for 12 cycles, then the scenarios in turn
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        done = 1'b0;
        rdy = 1'b0;
        rdata = 16'h0000;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_write();
        t_read();
        t_refuse();
        t_fill();
        t_compat();
        t_passive();
        t_shared();
        print_verdict();
    end
endmodule : tb

// File: src/shi_fifo.sv
`timescale 1ns/100ps
module shi_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic clk_in,
    input  wire logic nrst_in,
    input  wire logic ce_in,
    shi_fifo_if.fifo  f
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [CW-1:0]               cnt;
        logic [WIDTH-1:0]            odata;
        logic                        ovld;
    } shi_fifo_s;

    shi_fifo_s st;
    shi_fifo_s next_st;
    logic      push;
    logic      pop;

    // Registered output stage so the reader sees flop outputs only;
    // pointers wrap on their own, so DEPTH must be a power of two
    always_comb
    begin
        next_st = st;
        push = f.wvalid && (st.cnt != CW'(DEPTH));
        pop = (st.cnt != '0) && (!st.ovld || f.rready);
        if (st.ovld && f.rready)
            next_st.ovld = 1'b0;
        if (pop)
        begin
            next_st.odata = st.mem[st.rd];
            next_st.ovld = 1'b1;
            next_st.rd = st.rd + 1'b1;
        end
        if (push)
        begin
            next_st.mem[st.wr] = f.wdata;
            next_st.wr = st.wr + 1'b1;
        end
        next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st <= '0;
        else if (ce_in)
            st <= next_st;
    end

    assign f.wready = (st.cnt != CW'(DEPTH));
    assign f.rdata = st.odata;
    assign f.rvalid = st.ovld;
    assign f.count = st.cnt;
endmodule : shi_fifo

// File: src/shi_fifo_if.sv
`timescale 1ns/100ps
interface shi_fifo_if #(parameter int W = 32, parameter int CW = 5);
    logic [W-1:0]  wdata;
    logic          wvalid;
    logic          wready;
    logic [W-1:0]  rdata;
    logic          rvalid;
    logic          rready;
    logic [CW-1:0] count;

    modport fifo (input wdata, wvalid, rready, output wready, rdata, rvalid, count);
    modport user (output wdata, wvalid, rready, input wready, rdata, rvalid, count);
endinterface : shi_fifo_if

// File: src/shi_pkg.sv
package shi_pkg;
    // Command framing: instruction, address, one data word, MSB first
    localparam int         INSTR_W       = 8;
    localparam int         ADDR_W        = 8;
    localparam int         REG_W         = 16;
    localparam logic [7:0] CMD_READ      = 8'h03;
    localparam logic [7:0] CMD_WRITE     = 8'h02;
    localparam logic [5:0] INSTR_LAST    = 6'h07;
    localparam logic [5:0] ADDR_LAST     = 6'h0F;
    localparam logic [5:0] FRAME_LAST    = 6'h1F;
    localparam logic [5:0] FRAME_BITS    = 6'h20;

    // Local mode word, written through the command port
    localparam logic [7:0]  MODE_ADDR        = 8'h00;
    localparam int          MODE_NATIVE_POS  = 11;
    localparam int          MODE_SHARE_POS   = 10;
    localparam logic [15:0] MODE_RESET       = 16'h0800;

    // Stream path: bytes packed four to a word, first byte in the top lane
    localparam int         BYTE_W         = 8;
    localparam int         FIFO_WIDTH     = 32;
    localparam int         FIFO_DEPTH     = 16;
    localparam int         FIFO_CW        = 5;
    localparam int         BYTES_PER_WORD = FIFO_WIDTH / BYTE_W;
    localparam int         SAFE_BYTES     = 32;
    localparam int         SAFE_WORDS     = SAFE_BYTES / BYTES_PER_WORD;
    // One word spare for a partly assembled word
    localparam logic [4:0] DATA_REQUEST_MAX_FILL  = 5'(FIFO_DEPTH - SAFE_WORDS - 1);
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [1:0] LANE_LAST      = 2'h3;

    // Pin synchroniser order {sck, si, cs_n, byte_sync, stream_clock, stream_serial_in}
    localparam int         SYNC_W   = 6;
    localparam logic [5:0] SYNC_RST = 6'h0C;

    typedef enum logic [1:0] {CMD_HDR, CMD_WDATA, CMD_RDATA, CMD_DONE} shi_cmd_e;
endpackage : shi_pkg

// File: src/shi_sync.sv
`timescale 1ns/100ps
module shi_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_in,
    input  wire logic         nrst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } shi_sync_s;

    shi_sync_s st;
    shi_sync_s next_st;

    // First stage feeds only the second stage
    always_comb
    begin
        next_st.s1 = d_in;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            st <= {RST, RST};
        else if (ce_in)
            st <= next_st;
    end

    assign q_out = st.s2;
endmodule : shi_sync

// File: src/shi_top.sv
`timescale 1ns/100ps
module shi_top (
    input  wire logic                       CLK_IN,
    input  wire logic                       NRST_IN,
    input  wire logic                       CE_IN,
    input  wire logic                       SCK_IN,
    input  wire logic                       SI_IN,
    input  wire logic                       COMMAND_SELECT_N_IN,
    input  wire logic                       BYTE_SYNC_IN,
    input  wire logic                       STREAM_CLOCK_IN,
    input  wire logic                       STREAM_SERIAL_IN,
    input  wire logic [shi_pkg::REG_W-1:0]  REG_RDATA_IN,
    input  wire logic                       REG_DONE_IN,
    input  wire logic                       STREAM_READY_IN,
    output logic                            SO_OUT,
    output logic                            SO_OE_OUT,
    output logic                            DATA_REQUEST_OUT,
    output logic                            REG_WRITE_OUT,
    output logic                            REG_READ_OUT,
    output logic [shi_pkg::ADDR_W-1:0]      REG_ADDR_OUT,
    output logic [shi_pkg::REG_W-1:0]       REG_WDATA_OUT,
    output logic [shi_pkg::FIFO_WIDTH-1:0]  STREAM_DATA_OUT,
    output logic                            STREAM_VALID_OUT,
    output logic                            NATIVE_MODE_OUT,
    output logic                            SHARED_SELECT_OUT,
    output logic                            GENERAL_IO_TWO_OUT,
    output logic                            GENERAL_IO_THREE_OUT
);
    import shi_pkg::*;

    typedef struct packed {
        logic                  sck_d;
        logic                  stream_clock_d;
        logic                  byte_sync_d;
        shi_cmd_e              phase;
        logic [5:0]            cmd_cnt;
        logic [REG_W-1:0]      cmd_sh;
        logic [INSTR_W-1:0]    instr;
        logic [ADDR_W-1:0]     addr;
        logic [REG_W-1:0]      out_sh;
        logic                  load;
        logic                  so;
        logic                  so_oe;
        logic                  busy;
        logic                  reg_wr;
        logic                  reg_rd;
        logic [REG_W-1:0]      reg_wdata;
        logic [REG_W-1:0]      mode;
        logic [2:0]            st_cnt;
        logic                  st_act;
        logic [BYTE_W-1:0]     st_byte;
        logic [FIFO_WIDTH-1:0] asm_word;
        logic [1:0]            asm_n;
        logic                  word_vld;
        logic                  data_request;
        logic                  io_two;
        logic                  io_three;
    } shi_top_s;

    shi_top_s st;
    shi_top_s next_st;

    logic [SYNC_W-1:0] pins;
    logic              sck;
    logic              si;
    logic              cs_n;
    logic              byte_sync;
    logic              stream_clock;
    logic              stream_serial_in;
    logic              sck_rise;
    logic              sck_fall;
    logic              stream_clock_rise;
    logic              native;
    logic              share;
    logic [4:0]        fill;

    shi_fifo_if #(.W(FIFO_WIDTH), .CW(FIFO_CW)) fq ();

    // Every serial pin is foreign to CLK_IN, including the serial clocks
    shi_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
        .clk_in  (CLK_IN),
        .nrst_in (NRST_IN),
        .ce_in   (CE_IN),
        .d_in    ({SCK_IN, SI_IN, COMMAND_SELECT_N_IN, BYTE_SYNC_IN,
                   STREAM_CLOCK_IN, STREAM_SERIAL_IN}),
        .q_out   (pins)
    );

    shi_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in  (CLK_IN),
        .nrst_in (NRST_IN),
        .ce_in   (CE_IN),
        .f       (fq.fifo)
    );

    // Decoded pins and clock edges, all from synchronised levels
    assign {sck, si, cs_n, byte_sync, stream_clock, stream_serial_in} = pins;
    assign sck_rise = sck && !st.sck_d;
    assign sck_fall = !sck && st.sck_d;
    assign stream_clock_rise = stream_clock && !st.stream_clock_d;
    assign native = st.mode[MODE_NATIVE_POS];
    assign share = st.mode[MODE_SHARE_POS];
    assign fill = fq.count + 5'(st.word_vld);

    // Next-state logic for both ports and the request flag
    always_comb
    begin
        logic       take;
        logic       bitv;
        logic       restart;
        logic       sel_n;
        logic       byte_done;
        logic [2:0] cur;
        take = 1'b0;
        bitv = si;
        restart = 1'b0;
        sel_n = 1'b1;
        byte_done = 1'b0;
        cur = st.st_cnt;
        next_st = st;
        next_st.sck_d = sck;
        next_st.stream_clock_d = stream_clock;
        next_st.reg_wr = 1'b0;
        next_st.reg_rd = 1'b0;
        // Completion clears first, so a new command in the same cycle wins
        if (REG_DONE_IN)
            next_st.busy = 1'b0;

        // Command port, paced by serial clock edges
        if (cs_n)
        begin
            next_st.phase = CMD_HDR;
            next_st.cmd_cnt = '0;
            next_st.load = 1'b0;
            next_st.so = 1'b0;
            next_st.so_oe = 1'b0;
        end
        else
        begin
            if (sck_rise && st.cmd_cnt != FRAME_BITS)
            begin
                next_st.cmd_cnt = st.cmd_cnt + 6'h01;
                next_st.cmd_sh = {st.cmd_sh[REG_W-2:0], si};
                case (st.phase)
                    CMD_HDR:
                    begin
                        if (st.cmd_cnt == INSTR_LAST)
                        begin
                            next_st.instr = {st.cmd_sh[6:0], si};
                            // Unknown instructions are ignored to frame end
                            if (next_st.instr != CMD_READ && next_st.instr != CMD_WRITE)
                                next_st.phase = CMD_DONE;
                        end
                        if (st.cmd_cnt == ADDR_LAST)
                        begin
                            next_st.addr = {st.cmd_sh[6:0], si};
                            if (st.instr == CMD_READ)
                            begin
                                next_st.phase = CMD_RDATA;
                                next_st.reg_rd = 1'b1;
                                next_st.load = 1'b1;
                                next_st.busy = 1'b1;
                            end
                            else
                                next_st.phase = CMD_WDATA;
                        end
                    end
                    CMD_WDATA:
                    begin
                        if (st.cmd_cnt == FRAME_LAST)
                        begin
                            next_st.reg_wdata = {st.cmd_sh[REG_W-2:0], si};
                            next_st.reg_wr = 1'b1;
                            next_st.busy = 1'b1;
                            next_st.phase = CMD_DONE;
                            if (st.addr == MODE_ADDR)
                                next_st.mode = next_st.reg_wdata;
                        end
                    end
                    default:
                        ;
                endcase
            end
            // Read data leaves on falling edges; writes never enable SO
            if (sck_fall && st.phase == CMD_RDATA)
            begin
                next_st.so_oe = 1'b1;
                next_st.load = 1'b0;
                if (st.load)
                begin
                    next_st.so = REG_RDATA_IN[REG_W-1];
                    next_st.out_sh = {REG_RDATA_IN[REG_W-2:0], 1'b0};
                end
                else
                begin
                    next_st.so = st.out_sh[REG_W-1];
                    next_st.out_sh = {st.out_sh[REG_W-2:0], 1'b0};
                end
            end
        end

        // Stream port bit sampling
        if (native)
        begin
            sel_n = share ? !cs_n : byte_sync;
            if (sel_n)
                next_st.st_cnt = '0;
            else if (sck_rise)
                take = 1'b1;
        end
        else
        begin
            bitv = stream_serial_in;
            if (stream_clock_rise)
            begin
                next_st.byte_sync_d = byte_sync;
                // A sync rise restarts the byte even mid-byte
                if (byte_sync && (!st.st_act || !st.byte_sync_d))
                begin
                    restart = 1'b1;
                    take = 1'b1;
                    next_st.st_act = 1'b1;
                end
                else if (st.st_act && (!share || byte_sync))
                    take = 1'b1;
            end
        end
        if (take)
        begin
            cur = restart ? 3'h0 : st.st_cnt;
            next_st.st_byte = {st.st_byte[BYTE_W-2:0], bitv};
            if (cur == BIT_LAST)
            begin
                byte_done = 1'b1;
                next_st.st_cnt = '0;
                if (!native)
                    next_st.st_act = byte_sync;
            end
            else
                next_st.st_cnt = cur + 3'h1;
        end

        // Word assembly; a full queue holds the word and stalls packing
        if (st.word_vld && fq.wready)
            next_st.word_vld = 1'b0;
        if (byte_done && !next_st.word_vld)
        begin
            next_st.asm_word = {st.asm_word[FIFO_WIDTH-BYTE_W-1:0], next_st.st_byte};
            next_st.asm_n = st.asm_n + 2'h1;
            if (st.asm_n == LANE_LAST)
                next_st.word_vld = 1'b1;
        end

        // One request flag for both ports, recomputed every cycle even mid-byte
        next_st.data_request = !next_st.busy && (fill <= DATA_REQUEST_MAX_FILL);

        // Spare pins report their level in native mode only
        next_st.io_two = native && stream_clock;
        next_st.io_three = native && stream_serial_in;
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            st <= '0;
            st.mode <= MODE_RESET;
        end
        else if (CE_IN)
            st <= next_st;
    end

    // Port wiring
    assign fq.wdata = st.asm_word;
    assign fq.wvalid = st.word_vld;
    assign fq.rready = STREAM_READY_IN;
    assign STREAM_DATA_OUT = fq.rdata;
    assign STREAM_VALID_OUT = fq.rvalid;
    assign SO_OUT = st.so;
    assign SO_OE_OUT = st.so_oe;
    assign DATA_REQUEST_OUT = st.data_request;
    assign REG_WRITE_OUT = st.reg_wr;
    assign REG_READ_OUT = st.reg_rd;
    assign REG_ADDR_OUT = st.addr;
    assign REG_WDATA_OUT = st.reg_wdata;
    assign NATIVE_MODE_OUT = native;
    assign SHARED_SELECT_OUT = share;
    assign GENERAL_IO_TWO_OUT = st.io_two;
    assign GENERAL_IO_THREE_OUT = st.io_three;

    // Checks
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!NRST_IN);

    sequence cmd_end_s;
        CE_IN && (st.reg_wr || st.reg_rd);
    endsequence
    sequence deselect_s;
        CE_IN && cs_n;
    endsequence

    standby_release_a: assert property (deselect_s |=> !SO_OE_OUT && st.cmd_cnt == 6'h00)
        else $error("select high did not release output");
    write_hiz_a: assert property (st.phase != CMD_RDATA |-> !SO_OE_OUT)
        else $error("output driven outside a read");
    so_falling_a: assert property ($changed(SO_OUT) |-> $past(sck_fall || cs_n))
        else $error("output changed without a falling clock");
    first_bit_a: assert property (deselect_s ##1 (CE_IN && !cs_n) |-> st.cmd_cnt == 6'h00)
        else $error("first rising edge after select not counted as bit 0");
    sample_sel_a: assert property ($changed(st.cmd_cnt) && st.cmd_cnt != 6'h00
        |-> $past(sck_rise && !cs_n))
        else $error("bit taken without rising edge and select");
    shared_sel_a: assert property (CE_IN && native && share && !cs_n |=> st.st_cnt == 3'h0)
        else $error("stream framed while command selected");
    mode_reset_a: assert property ($rose(NRST_IN) |-> st.mode == MODE_RESET)
        else $error("mode not native after reset");
    data_request_room_a: assert property (CE_IN && (next_st.busy || fill > DATA_REQUEST_MAX_FILL)
        |=> !DATA_REQUEST_OUT)
        else $error("request high without room");
    // A completion seen on the pulse edge may raise the request one cycle later
    cmd_data_request_a: assert property (cmd_end_s |-> !DATA_REQUEST_OUT
        ##1 (!DATA_REQUEST_OUT || $past(REG_DONE_IN)))
        else $error("request not dropped after command");
endmodule : shi_top
